/* verilog/irq_cfg.svh */
// Constants of the asynchronous trap interrupt controller.
// Assumes inclusion by bare name from the design files.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// Register byte offsets, one aligned word each
`define IRQ_ADR_PENDING 8'h00
`define IRQ_ADR_MASK 8'h04
`define IRQ_ADR_CLEAR 8'h08
`define IRQ_ADR_SHAPE 8'h0c
`define IRQ_ADR_FORCE 8'h10
`define IRQ_ADR_STATUS 8'h14

// Reset values
`define IRQ_RST_MASK 16'h0000
`define IRQ_RST_SHAPE 14'h0000
`define IRQ_RST_PIN 5'h1f

// Fixed levels of the internal sources
`define LVL_WDOG 4'hf
`define LVL_RTC 4'hd
`define LVL_GPT 4'hc
`define LVL_DMA_TMO 4'h9
`define LVL_DMA_ACC 4'h8
`define LVL_UART_ERR 4'h7
`define LVL_MEM_CORR 4'h6
`define LVL_UART_B 4'h5
`define LVL_UART_A 4'h4
`define LVL_HW_ERR 4'h1

// Levels of external inputs 0 to 4
`define LVL_EXT0 4'h2
`define LVL_EXT1 4'h3
`define LVL_EXT2 4'ha
`define LVL_EXT3 4'hb
`define LVL_EXT4 4'he

// Trap type is this base plus the level
`define TT_BASE 8'h10
// Trap type field position within the trap address
`define TT_LSB 4
// Status register field positions
`define STAT_TT_LSB 8

`endif

/* verilog/irq_pkg.sv */
// Types of the asynchronous trap interrupt controller.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_pkg;

    // One bit per level, bit 0 unused
    typedef logic [15:0] lvl_vec_t;
    typedef logic [3:0] level_t;

    // Single-cycle event pulses from internal sources
    typedef struct packed {
        logic wdog;
        logic rtc;
        logic gpt;
        logic dma_tmo;
        logic dma_acc;
        logic uart_err;
        logic mem_corr;
        logic uart_b;
        logic uart_a;
    } int_src_t;

    // Shape setting for the external lines
    typedef struct packed {
        logic ack_en;
        logic [2:0] ack_sel;
        logic [4:0] edge_sel;
        logic [4:0] pol_high;
    } shape_t;

endpackage : irq_pkg

/* verilog/async_trap_interrupt_controller.sv */
// Prioritising interrupt controller with a Wishbone register slave.
// Assumes internal events are pulses on clk_i and the external lines
// are asynchronous pins. Acknowledge and trap address come from the
// processor on clk_i.
//
// Overview of operation
// - Fifteen event sources, one level each
// - Trap type is 0x10 plus level
// - Internal sources sit on fixed levels
// - External inputs 0-4 at 2,3,10,11,14
// - Per-source mask, level 15 never masked
// - Readable pending bits, write-one clear
// - Acknowledge clears pending bit by trap address
// - Pending interrupt drives its level out
// - Highest pending level is presented
// - Higher level replaces unacknowledged lower
// - Shape selects polarity and edge/level
// - Selected external ack gives pulse
// - External input needs two active cycles
// - Edge mode sets on active transition
// - Level mode follows line state
// - Masked hardware error sets level 1
// - Watchdog timeout sets level 15
// - DMA timeout sets level 9
// - DMA access error sets level 8
// - UART ready per channel, shared error
// - Corrected memory error sets level 6
// - Real time tick and timer expiry
`timescale 1ns/1ps
`include "irq_cfg.svh"

module async_trap_interrupt_controller #(
    parameter int N_HW_ERR = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input irq_pkg::int_src_t int_src_i,
    input wire logic [N_HW_ERR-1:0] hw_err_flags_i,
    input wire logic [N_HW_ERR-1:0] hw_err_masked_i,
    input wire logic [4:0] ext_irq_i,
    input wire logic int_ack_i,
    input wire logic [11:0] ack_trap_addr_i,
    output logic [3:0] interrupt_request_level_o,
    output logic external_ack_pulse_out_o
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (N_HW_ERR < 1 || N_HW_ERR > 32) begin : g_bad_hw_err
        $error("N_HW_ERR must lie between 1 and 32");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Level of external input k
    function automatic irq_pkg::level_t ext_level(input logic [2:0] k);
        irq_pkg::level_t l;
        l = 4'h0;
        unique case (k)
            3'h0: l = `LVL_EXT0;
            3'h1: l = `LVL_EXT1;
            3'h2: l = `LVL_EXT2;
            3'h3: l = `LVL_EXT3;
            3'h4: l = `LVL_EXT4;
            default: l = 4'h0;
        endcase
        return l;
    endfunction : ext_level

    // Highest set level, zero when none
    function automatic irq_pkg::level_t highest_level(input irq_pkg::lvl_vec_t v);
        irq_pkg::level_t l;
        l = 4'h0;
        for (int i = 1; i < 16; i++) begin
            if (v[i]) begin
                l = 4'(i);
            end
        end
        return l;
    endfunction : highest_level

    // Trap type of a level
    function automatic logic [7:0] level_to_trap_type(input irq_pkg::level_t l);
        return `TT_BASE + {4'h0, l};
    endfunction : level_to_trap_type

    // One-hot of a level
    function automatic irq_pkg::lvl_vec_t level_bit(input irq_pkg::level_t l);
        return 16'h0001 << l;
    endfunction : level_bit

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0] sel);
        return {sel[1] ? new_v[15:8] : old_v[15:8],
                sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge16

    // ****************************************************************
    // Declarations
    // ****************************************************************
    irq_pkg::lvl_vec_t pend_reg;
    irq_pkg::lvl_vec_t pend_next;
    irq_pkg::lvl_vec_t mask_reg;
    irq_pkg::lvl_vec_t eff_vec;
    irq_pkg::lvl_vec_t set_vec;
    irq_pkg::lvl_vec_t clr_vec;
    irq_pkg::lvl_vec_t bus_clr;
    irq_pkg::lvl_vec_t bus_force;
    irq_pkg::lvl_vec_t ack_clr;
    irq_pkg::shape_t shape_reg;
    irq_pkg::level_t irl_reg;
    irq_pkg::level_t ack_lvl;
    logic [7:0] ack_tt;
    logic ack_valid;
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_stable_reg;
    logic [4:0] ext_act;
    logic [4:0] act_d_reg;
    logic [4:0] ext_filt_reg;
    logic [4:0] filt_d_reg;
    logic [4:0] ext_edge;
    logic hw_err_masked;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic pulse_reg;
    logic bus_req;
    logic bus_wr;
    logic [7:0] adr_w;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************

    // Request decode, taken once per access
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr = bus_req & wb_we_i;
    assign adr_w = {wb_adr_i[7:2], 2'b00};

    // Acknowledge one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // Read data; unmapped and write-only words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req) begin
            rdata_reg <= 32'h0000_0000;
            unique case (adr_w)
                `IRQ_ADR_PENDING: rdata_reg[15:0] <= pend_reg;
                `IRQ_ADR_MASK: rdata_reg[15:0] <= mask_reg;
                `IRQ_ADR_SHAPE: rdata_reg[13:0] <= shape_reg;
                `IRQ_ADR_STATUS: begin
                    rdata_reg[3:0] <= irl_reg;
                    rdata_reg[`STAT_TT_LSB +: 8] <= (irl_reg != 4'h0) ?
                        level_to_trap_type(irl_reg) : 8'h00;
                end
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ****************************************************************
    // Mask and shape registers
    // ****************************************************************

    // Mask, level 15 and bit 0 fixed clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= `IRQ_RST_MASK;
        end else if (bus_wr && adr_w == `IRQ_ADR_MASK) begin
            mask_reg <= merge16(mask_reg, wb_dat_i[15:0], wb_sel_i[1:0])
                        & 16'h7ffe;
        end
    end

    // Polarity, edge select and ack pulse select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shape_reg <= `IRQ_RST_SHAPE;
        end else if (bus_wr && adr_w == `IRQ_ADR_SHAPE) begin
            shape_reg <= 14'(merge16({2'b00, shape_reg}, wb_dat_i[15:0],
                                     wb_sel_i[1:0]));
        end
    end

    // Write-one clear and forced set strobes
    always_comb begin
        bus_clr = 16'h0000;
        bus_force = 16'h0000;
        if (bus_wr && adr_w == `IRQ_ADR_CLEAR) begin
            bus_clr = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        if (bus_wr && adr_w == `IRQ_ADR_FORCE) begin
            bus_force = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        bus_clr[0] = 1'b0;
        bus_force[0] = 1'b0;
    end

    // ****************************************************************
    // External line conditioning
    // ****************************************************************

    // Three-stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= `IRQ_RST_PIN;
            pin_s2_reg <= `IRQ_RST_PIN;
            pin_s3_reg <= `IRQ_RST_PIN;
        end else begin
            pin_s1_reg <= ext_irq_i;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_stable_reg <= `IRQ_RST_PIN;
        end else begin
            for (int k = 0; k < 5; k++) begin
                if (pin_s2_reg[k] == pin_s3_reg[k]) begin
                    pin_stable_reg[k] <= pin_s3_reg[k];
                end
            end
        end
    end

    // Polarity, active when line matches setting
    assign ext_act = ~(pin_stable_reg ^ shape_reg.pol_high);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_d_reg <= 5'h00;
            ext_filt_reg <= 5'h00;
            filt_d_reg <= 5'h00;
        end else begin
            act_d_reg <= ext_act;
            ext_filt_reg <= ext_act & act_d_reg;
            filt_d_reg <= ext_filt_reg;
        end
    end

    assign ext_edge = ext_filt_reg & ~filt_d_reg;

    // ****************************************************************
    // Acknowledge decode
    // ****************************************************************

    // Trap type from the acknowledge trap address
    assign ack_tt = ack_trap_addr_i[`TT_LSB +: 8];
    assign ack_valid = int_ack_i && (ack_tt & 8'hf0) == `TT_BASE
                       && ack_tt[3:0] != 4'h0;
    assign ack_lvl = ack_tt[3:0];
    assign ack_clr = ack_valid ? level_bit(ack_lvl) : 16'h0000;

    // Pulse when the selected external line is acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= ack_valid && shape_reg.ack_en
                         && shape_reg.ack_sel <= 3'h4
                         && ack_lvl == ext_level(shape_reg.ack_sel);
        end
    end

    assign external_ack_pulse_out_o = pulse_reg;

    // ****************************************************************
    // Pending bits
    // ****************************************************************

    assign hw_err_masked = |(hw_err_flags_i & hw_err_masked_i);

    // Gather set events onto their levels
    always_comb begin
        set_vec = bus_force;
        set_vec[`LVL_WDOG] = set_vec[`LVL_WDOG] | int_src_i.wdog;
        // Real time tick and timer expiry
        set_vec[`LVL_RTC] = set_vec[`LVL_RTC] | int_src_i.rtc;
        set_vec[`LVL_GPT] = set_vec[`LVL_GPT] | int_src_i.gpt;
        set_vec[`LVL_DMA_TMO] = set_vec[`LVL_DMA_TMO] | int_src_i.dma_tmo;
        set_vec[`LVL_DMA_ACC] = set_vec[`LVL_DMA_ACC] | int_src_i.dma_acc;
        // UART ready per channel, shared error
        set_vec[`LVL_UART_ERR] = set_vec[`LVL_UART_ERR] | int_src_i.uart_err;
        set_vec[`LVL_UART_B] = set_vec[`LVL_UART_B] | int_src_i.uart_b;
        set_vec[`LVL_UART_A] = set_vec[`LVL_UART_A] | int_src_i.uart_a;
        set_vec[`LVL_MEM_CORR] = set_vec[`LVL_MEM_CORR] | int_src_i.mem_corr;
        set_vec[`LVL_HW_ERR] = set_vec[`LVL_HW_ERR] | hw_err_masked;
        for (int k = 0; k < 5; k++) begin
            if (shape_reg.edge_sel[k] && ext_edge[k]) begin
                set_vec = set_vec | level_bit(ext_level(3'(k)));
            end
        end
    end

    assign clr_vec = bus_clr | ack_clr;

    // Set wins over clear; level lines follow the line
    always_comb begin
        pend_next = (pend_reg & ~clr_vec) | set_vec;
        // Level mode tracks the filtered line
        for (int k = 0; k < 5; k++) begin
            if (!shape_reg.edge_sel[k]) begin
                pend_next[ext_level(3'(k))] = ext_filt_reg[k]
                    | bus_force[ext_level(3'(k))];
            end
        end
        pend_next[0] = 1'b0;
    end

    // Pending register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 16'h0000;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // ****************************************************************
    // Level request
    // ****************************************************************

    assign eff_vec = pend_reg & ~mask_reg;

    // Highest level, replaced when a higher one arrives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irl_reg <= 4'h0;
        end else begin
            irl_reg <= highest_level(eff_vec);
        end
    end

    assign interrupt_request_level_o = irl_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_wdog_unmaskable;
        pend_reg[`LVL_WDOG] |=> irl_reg == 4'hf;
    endproperty
    a_wdog_unmaskable: assert property (p_wdog_unmaskable)
        else $error("Level 15 pending but not presented");

    property p_highest;
        (irl_reg != 4'h0) |-> ($past(eff_vec) >> irl_reg) == 16'h0001;
    endproperty
    a_highest: assert property (p_highest)
        else $error("Presented level is not the highest unmasked one");

    property p_idle_zero;
        (eff_vec == 16'h0000) |=> irl_reg == 4'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("Level not zero with nothing pending");

    property p_wdog_set;
        int_src_i.wdog |=> pend_reg[15] ##1 irl_reg == 4'hf;
    endproperty
    a_wdog_set: assert property (p_wdog_set)
        else $error("Watchdog timeout not raised at level 15");

    property p_sw_clear;
        (bus_clr[13] && !set_vec[13]) |=> !pend_reg[13];
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("Clear write left level 13 pending");

    property p_ack_clear;
        (int_ack_i && ack_tt == 8'h1c && !set_vec[12]) |=> !pend_reg[12];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("Acknowledge of trap 0x1c left level 12 pending");

    property p_filter;
        ext_filt_reg[0] |-> $past(ext_act[0]) && $past(ext_act[0], 2);
    endproperty
    a_filter: assert property (p_filter)
        else $error("External line recognised before two active cycles");

    property p_level_follow;
        (!shape_reg.edge_sel[0] && !ext_filt_reg[0] && !bus_force[2])
            |=> !pend_reg[2];
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("Level-mode pending stayed after line released");

    property p_edge_set;
        (shape_reg.edge_sel[4] && ext_edge[4]) |=> pend_reg[14];
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("Edge on external 4 did not set level 14");

    property p_ack_pulse;
        (ack_valid && ack_lvl == 4'he && shape_reg.ack_en
         && shape_reg.ack_sel == 3'h4)
            |=> external_ack_pulse_out_o ##1 !external_ack_pulse_out_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("Missing one-cycle external ack pulse");

    property p_hw_err;
        hw_err_masked |=> pend_reg[1];
    endproperty
    a_hw_err: assert property (p_hw_err)
        else $error("Masked hardware error did not set level 1");

    property p_bus_ack;
        bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("Bus access not acknowledged in one cycle");

    c_level15: cover property (irl_reg == 4'hf);
    c_preempt: cover property ((irl_reg != 4'h0) ##1
                               (irl_reg > $past(irl_reg)));
    c_ext_pulse: cover property (external_ack_pulse_out_o);
    c_ack_clear: cover property (ack_valid && pend_reg[ack_lvl]);

endmodule : async_trap_interrupt_controller

/* verilog/async_trap_interrupt_controller_end.sv */
`timescale 1ns/1ps
// (intentionally left as part of repository layout)

/* tb/iu_model.sv */
// Processor-side model: watches the request level and acknowledges it.
// Assumes level_i is registered on clk_i; lat_i of 2 or more cycles.
`timescale 1ns/1ps
module iu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [3:0] lat_i,
    input wire logic [3:0] level_i,
    output logic ack_o,
    output logic [11:0] addr_o
);
    logic [3:0] wait_reg;
    logic go;

    // Acknowledge once the wait reaches the chosen latency
    assign go = en_i && level_i != 4'h0 && wait_reg == lat_i && !ack_o;

    // Wait counter and one-cycle acknowledge pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i || level_i == 4'h0 || ack_o) begin
            wait_reg <= 4'h0;
            ack_o <= 1'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
            ack_o <= go;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_o <= 12'h5a5;
        end else if (go) begin
            addr_o <= {8'h10 + {4'h0, level_i}, 4'h0};
        end else begin
            addr_o <= ~addr_o; // Unqualified address keeps moving
        end
    end
endmodule : iu_model

/* tb/async_trap_interrupt_controller_tb.sv */
// Bench for the interrupt controller: bus, sources, external lines, acknowledge.
// Assumes the processor model beside it and one 50 MHz clock.
`timescale 1ns/1ps
module async_trap_interrupt_controller_tb;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rq;
    logic ack;
    irq_pkg::int_src_t src = '0;
    logic [7:0] herr = 8'h00;
    logic [7:0] hmsk = 8'h00;
    logic [4:0] ext = 5'h1f;
    logic iu_en = 1'h0;
    logic [3:0] iu_lat = 4'h2;
    logic iu_ack;
    logic [11:0] iu_adr;
    logic [3:0] lvl;
    logic xack;
    int n_mismatch = 0;
    int checks = 0;

    async_trap_interrupt_controller i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .int_src_i(src),
        .hw_err_flags_i(herr), .hw_err_masked_i(hmsk), .ext_irq_i(ext),
        .int_ack_i(iu_ack), .ack_trap_addr_i(iu_adr),
        .interrupt_request_level_o(lvl), .external_ack_pulse_out_o(xack));

    iu_model i_iu (.clk_i(clk_i), .rst_i(rst_i), .en_i(iu_en), .lat_i(iu_lat),
        .level_i(lvl), .ack_o(iu_ack), .addr_o(iu_adr));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // ************
    // Shared tasks
    // ************
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        cyc <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        chk("bus ack", 32'h1, {31'h0, ack});
        if (ack !== 1'h1) tally_and_finish();
        rq = rdat;
        cyc <= 1'h0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_lvl(input logic [3:0] e);
        int n;
        n = 0;
        while (lvl !== e && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk("request level", {28'h0, e}, {28'h0, lvl});
        if (lvl !== e) tally_and_finish();
    endtask : wait_lvl

    task automatic fire(input logic [8:0] b);
        src <= b;
        @(posedge clk_i);
        src <= '0;
    endtask : fire

    // *********
    // Scenarios
    // *********
    task automatic t_regs();
        chk("idle level", 32'h0, {28'h0, lvl});
        wb(1'h1, 8'h3c, 16'hffff);
        wb(1'h0, 8'h3c, 16'h0);
        chk("unmapped", 32'h0, rq);
        wb(1'h1, 8'h04, 16'hffff);
        wb(1'h0, 8'h04, 16'h0);
        chk("mask", 32'h7ffe, rq);
        fire(9'h040);
        tick(6);
        chk("masked level", 32'h0, {28'h0, lvl});
        fire(9'h100);
        wait_lvl(4'hf);
        wb(1'h1, 8'h08, 16'hffff);
        wb(1'h1, 8'h04, 16'h0);
        wait_lvl(4'h0);
    endtask : t_regs

    task automatic t_sources();
        logic [3:0] lv [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd, 4'hf};
        for (int i = 0; i < 9; i++) begin
            fire(9'h1 << i);
            wait_lvl(lv[i]);
            wb(1'h0, 8'h00, 16'h0);
            chk("pending", 32'h1 << lv[i], rq);
            wb(1'h1, 8'h08, 16'h1 << lv[i]);
            wait_lvl(4'h0);
        end
    endtask : t_sources

    task automatic t_prio();
        fire(9'h041);
        wait_lvl(4'hc);
        fire(9'h100);
        wait_lvl(4'hf);
        wb(1'h0, 8'h14, 16'h0);
        chk("status", 32'h1f0f, rq);
        wb(1'h1, 8'h08, 16'hffff);
        wb(1'h1, 8'h10, 16'h0200);
        wait_lvl(4'h9);
        wb(1'h1, 8'h08, 16'hffff);
        herr <= 8'h01;
        tick(6);
        chk("unmasked error", 32'h0, {28'h0, lvl});
        hmsk <= 8'h01;
        wait_lvl(4'h1);
        herr <= 8'h00;
        wb(1'h1, 8'h08, 16'hffff);
        wait_lvl(4'h0);
    endtask : t_prio

    task automatic t_ext();
        logic [3:0] el [5] = '{4'h2, 4'h3, 4'ha, 4'hb, 4'he};
        ext <= 5'h1e;
        @(posedge clk_i);
        ext <= 5'h1f;
        tick(12);
        chk("glitch level", 32'h0, {28'h0, lvl});
        for (int i = 0; i < 5; i++) begin
            ext <= ~(5'h01 << i);
            wait_lvl(el[i]);
            wb(1'h1, 8'h08, 16'hffff);
            tick(4);
            chk("held level", {28'h0, el[i]}, {28'h0, lvl});
            ext <= 5'h1f;
            wait_lvl(4'h0);
        end
    endtask : t_ext

    task automatic t_edge();
        ext <= 5'h1b;
        wait_lvl(4'ha);
        wb(1'h1, 8'h0c, 16'h0084);
        wb(1'h1, 8'h08, 16'hffff);
        wait_lvl(4'h0);
        ext <= 5'h1f;
        wait_lvl(4'ha);
        ext <= 5'h1b;
        tick(12);
        chk("edge latched", 32'ha, {28'h0, lvl});
        wb(1'h1, 8'h08, 16'hffff);
        wait_lvl(4'h0);
        wb(1'h1, 8'h0c, 16'h0000);
        ext <= 5'h1f;
        tick(12);
        wait_lvl(4'h0);
    endtask : t_edge

    task automatic t_ack();
        int n;
        logic seen;
        wb(1'h1, 8'h0c, 16'h3200);
        iu_lat <= 4'h9;
        iu_en <= 1'h1;
        fire(9'h080);
        wait_lvl(4'hd);
        wait_lvl(4'h0);
        iu_lat <= 4'h2;
        ext <= 5'h0f;
        n = 0;
        seen = 1'h0;
        while (!seen && n < 60) begin
            @(posedge clk_i);
            seen = (xack === 1'h1);
            n++;
        end
        chk("ext ack pulse", 32'h1, {31'h0, seen});
        wait_lvl(4'h0);
        iu_en <= 1'h0;
        ext <= 5'h1f;
        wb(1'h1, 8'h0c, 16'h0000);
    endtask : t_ack

    // Reset, then every scenario in turn
    initial begin
        tick(8);
        rst_i <= 1'h0;
        tick(8);
        t_regs();
        t_sources();
        t_prio();
        t_ext();
        t_edge();
        t_ack();
        tally_and_finish();
    end
endmodule : async_trap_interrupt_controller_tb
